// ### hmf_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef HMF_REGS_VH
`define HMF_REGS_VH
// ============================================================
// register offsets
`define HMF_OFF_MODE       8'h01
`define HMF_OFF_SLOT_FIRST 8'h04
`define HMF_OFF_SLOT_LAST  8'h0b
`define HMF_OFF_FIRE       8'h0c
`define HMF_OFF_STEADY     8'h16
`define HMF_OFF_PEAK       8'h17
`define HMF_OFF_LIBSEL     8'h1a
`define HMF_OFF_CTRL1      8'h1b
`define HMF_OFF_CTRL2      8'h1c
`define HMF_OFF_CTRL3      8'h1d
`define HMF_OFF_STATUS     8'h00
`define HMF_OFF_RT_LEVEL   8'h02
// ============================================================
// field positions
`define HMF_MODE_LSB       0
`define HMF_MODE_MSB       2
`define HMF_HOLD_BIT       6
`define HMF_DEVRST_BIT     7
`define HMF_SHORT_BIT      0
`define HMF_BUSY_BIT       1
`define HMF_KIND_BIT       1
`define HMF_OPENLOOP_BIT   5
`define HMF_LRA_BIT        7
`define HMF_DRIVE_MSB      4
`define HMF_DECAY_LSB      0
`define HMF_DECAY_MSB      3
`define HMF_BLANK_LSB      4
`define HMF_BLANK_MSB      7
`define HMF_ZC_LSB         0
`define HMF_ZC_MSB         1
// ============================================================
// mode codes
`define HMF_MODE_SOFT      3'h0
`define HMF_MODE_EDGE      3'h1
`define HMF_MODE_LEVEL     3'h2
`define HMF_MODE_EXTIN     3'h3
`define HMF_MODE_RT        3'h5
`define HMF_MODE_DIAG      3'h6
`define HMF_MODE_CAL       3'h7
// ============================================================
// reset values
`define HMF_RST_MODE       8'h40
`define HMF_RST_STEADY     8'h3e
`define HMF_RST_PEAK       8'h8c
`define HMF_RST_CTRL1      8'h13
`define HMF_RST_CTRL2      8'h35
`define HMF_RST_CTRL3      8'h01
// ============================================================
// timing: base unit of sense intervals, in ns
`define HMF_TICK_NS        5000
`define HMF_CLK_NS         5
`define HMF_TICK_CYC       (`HMF_TICK_NS / `HMF_CLK_NS)
`define HMF_PROC_CYC       20000
`endif

// ### hmf_sense_timer.v
// back-emf sense sequencer: drive, decay, blanking, zero-cross window
`timescale 1ns/1ps
`include "hmf_regs.vh"
module hmf_sense_timer #(
  parameter TICK_CYC = `HMF_TICK_CYC
) (
  input  wire       core_clk,
  input  wire       srst,
  input  wire       run,
  input  wire [4:0] drive_time,
  input  wire [3:0] decay_time,
  input  wire [3:0] blank_time,
  input  wire [1:0] zc_time,
  input  wire       zc_seen,
  output reg        hiz_reg,
  output reg        convert_reg,
  output reg [4:0]  half_period_reg
);
  localparam ST_DRIVE = 2'h0;
  localparam ST_DECAY = 2'h1;
  localparam ST_BLANK = 2'h2;
  localparam ST_ZC    = 2'h3;
  reg [1:0]  state_reg;
  reg [15:0] tick_reg;
  reg [5:0]  cnt_reg;
  wire       tick = (tick_reg == 16'h0000);
  always @(posedge core_clk)
  begin
    if (srst || !run)
    begin
      state_reg       <= ST_DRIVE;
      tick_reg        <= 16'h0000;
      cnt_reg         <= 6'h00;
      hiz_reg         <= 1'b0;
      convert_reg     <= 1'b0;
      if (srst || !run)
        half_period_reg <= drive_time; // RL16
    end
    else
    begin
      tick_reg <= tick ? TICK_CYC[15:0] - 16'h0001 : tick_reg - 16'h0001;
      if (tick)
      begin
        cnt_reg <= cnt_reg + 6'h01;
        case (state_reg)
          ST_DRIVE:
          begin
            if (cnt_reg >= {1'b0, half_period_reg})
            begin
              state_reg <= ST_DECAY; // RL17
              cnt_reg   <= 6'h00;
            end
          end
          ST_DECAY:
          begin
            if (cnt_reg >= {2'b00, decay_time})
            begin
              state_reg <= ST_BLANK;
              hiz_reg   <= 1'b1; // RL17
              cnt_reg   <= 6'h00;
            end
          end
          ST_BLANK:
          begin
            if (cnt_reg >= {2'b00, blank_time})
            begin
              state_reg   <= ST_ZC;
              convert_reg <= 1'b1; // RL18
              cnt_reg     <= 6'h00;
            end
          end
          ST_ZC:
          begin
            if (cnt_reg >= {4'h0, zc_time}) // RL19
            begin
              state_reg   <= ST_DRIVE;
              hiz_reg     <= 1'b0;
              convert_reg <= 1'b0;
              cnt_reg     <= 6'h00;
              // tracker nudges the half period toward the crossing
              if (zc_seen && half_period_reg != 5'h00)
                half_period_reg <= half_period_reg - 5'h01; // RL16
              else if (!zc_seen && half_period_reg != 5'h1f)
                half_period_reg <= half_period_reg + 5'h01;
            end
          end
          default: state_reg <= ST_DRIVE;
        endcase
      end
    end
  end
endmodule // hmf_sense_timer

// ### hmf_fire_ctrl.v
// mode selection, fire control, short handling and level codes
// What this block does
// [RL1] mode 0 soft trigger, 1 edge trigger, 2 level trigger
// [RL2] mode 3 external input; kind bit picks analog or pulse width
// [RL3] mode 5 realtime, 6 diagnostics, 7 calibration
// [RL4] processes start only on the internal fire signal
// [RL5] host writes 0x01 to fire register to start playback
// [RL6] playback walks slot registers 0x04..0x0b; fire also starts cal/diag
// [RL7] fire bit reads 1 while playing, self clears at end
// [RL8] writing fire bit to 0 cancels playback at once
// [RL9] in trigger modes fire bit mirrors external trigger
// [RL10] realtime or pulse-width mode fires without touching stored bit
// [RL11] after a prior short host must change mode to resume
// [RL12] output short sets flag while present and cuts drive
// [RL13] short checked only during a running process
// [RL14] open-loop resonant mode toggles at programmed frequency
// [RL15] regulator short shuts down, restarts at defaults
// [RL16] drive-time field seeds tracker half period or sample rate
// [RL17] decay interval held before switching to high impedance
// [RL18] blanking interval before back-emf conversion
// [RL19] two-bit field sets minimum zero-cross window
// [RL20] steady-level code sets closed-loop level
// [RL21] open loop uses peak-limit code as full scale
// [RL22] closed loop clamps level to peak limit
// [RL23] host writes levels before calibration, reruns after change
// [RL24] resonant peak equals step times peak-limit code
// [RL25] hold bit stops playback at once, keeps registers
// [RL26] internal fire is OR of stored bit, trigger, rt/pwm mode
`timescale 1ns/1ps
`include "hmf_regs.vh"
module hmf_fire_ctrl #(
  parameter PROC_CYC = `HMF_PROC_CYC,
  parameter SLOTS    = 8
) (
  input  wire       core_clk,
  input  wire       srst,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_reg,
  input  wire       ext_trig,
  input  wire       out_short,
  input  wire       regulator_short,
  input  wire       zc_seen,
  input  wire       wave_done,
  output reg        fire_signal_reg,
  output reg  [7:0] wave_id_reg,
  output reg        wave_start_reg,
  output reg        cal_run_reg,
  output reg        diag_run_reg,
  output reg        drive_enable_reg,
  output reg  [7:0] drive_level_reg,
  output reg        ol_toggle_reg,
  output reg        hiz_reg,
  output reg        convert_reg
);
  // ============================================================
  // input synchronisers
  reg  [1:0] trig_sync_reg;
  reg  [1:0] short_sync_reg;
  reg  [1:0] rshort_sync_reg;
  reg  [1:0] zc_sync_reg;
  reg        trig_prev_reg;
  always @(posedge core_clk)
  begin
    trig_sync_reg   <= {trig_sync_reg[0], ext_trig};
    short_sync_reg  <= {short_sync_reg[0], out_short};
    rshort_sync_reg <= {rshort_sync_reg[0], regulator_short};
    zc_sync_reg     <= {zc_sync_reg[0], zc_seen};
    trig_prev_reg   <= trig_sync_reg[1];
  end
  wire trig  = trig_sync_reg[1];
  wire rshrt = rshort_sync_reg[1];
  // ============================================================
  // register file
  reg  [7:0] mode_reg;
  reg  [7:0] slot_reg [0:SLOTS-1];
  reg        fire_bit_reg;
  reg  [7:0] steady_reg;
  reg  [7:0] peak_reg;
  reg  [7:0] libsel_reg;
  reg  [7:0] ctrl1_reg;
  reg  [7:0] ctrl2_reg;
  reg  [7:0] ctrl3_reg;
  reg  [7:0] rt_level_reg;
  reg        short_flag_reg;
  reg        short_lock_reg;
  reg        busy_reg;
  reg  [2:0] slot_idx_reg;
  reg  [15:0] proc_cnt_reg;
  wire [2:0] mode     = mode_reg[`HMF_MODE_MSB:`HMF_MODE_LSB];
  wire       hold     = mode_reg[`HMF_HOLD_BIT];
  wire       kind_pwm = ctrl3_reg[`HMF_KIND_BIT]; // RL2
  wire       open_lp  = ctrl3_reg[`HMF_OPENLOOP_BIT];
  wire       is_lra   = libsel_reg[`HMF_LRA_BIT];
  wire       trig_md  = (mode == `HMF_MODE_EDGE) || (mode == `HMF_MODE_LEVEL); // RL1
  wire       stream_md = (mode == `HMF_MODE_RT) ||
                         ((mode == `HMF_MODE_EXTIN) && kind_pwm); // RL10
  wire       wr_mode  = reg_wr && (reg_addr == `HMF_OFF_MODE);
  wire       wr_fire  = reg_wr && (reg_addr == `HMF_OFF_FIRE);
  wire       dev_rst  = srst || rshrt ||
                        (wr_mode && reg_wdata[`HMF_DEVRST_BIT]); // RL15
  // trigger edge or level per mode
  wire       trig_fire = (mode == `HMF_MODE_EDGE) ? (trig && !trig_prev_reg) :
                         (mode == `HMF_MODE_LEVEL) ? trig : 1'b0;
  wire       fire_next = fire_bit_reg || (trig_md && trig_fire) || stream_md; // RL26
  wire       can_run   = !hold && !short_lock_reg;
  wire       last_slot = (slot_idx_reg == SLOTS[2:0] - 3'h1) ||
                         (slot_reg[slot_idx_reg + 3'h1] == 8'h00);
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1)
    begin : g_slot
      always @(posedge core_clk)
      begin
        if (dev_rst)
          slot_reg[g] <= 8'h00;
        else if (reg_wr && reg_addr == `HMF_OFF_SLOT_FIRST + g)
          slot_reg[g] <= reg_wdata; // RL6
      end
    end
  endgenerate
  always @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      mode_reg     <= `HMF_RST_MODE;
      steady_reg   <= `HMF_RST_STEADY;
      peak_reg     <= `HMF_RST_PEAK;
      libsel_reg   <= 8'h00;
      ctrl1_reg    <= `HMF_RST_CTRL1;
      ctrl2_reg    <= `HMF_RST_CTRL2;
      ctrl3_reg    <= `HMF_RST_CTRL3;
      rt_level_reg <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `HMF_OFF_MODE:     mode_reg     <= {1'b0, reg_wdata[6:0]};
        `HMF_OFF_STEADY:   steady_reg   <= reg_wdata;
        `HMF_OFF_PEAK:     peak_reg     <= reg_wdata;
        `HMF_OFF_LIBSEL:   libsel_reg   <= reg_wdata;
        `HMF_OFF_CTRL1:    ctrl1_reg    <= reg_wdata;
        `HMF_OFF_CTRL2:    ctrl2_reg    <= reg_wdata;
        `HMF_OFF_CTRL3:    ctrl3_reg    <= reg_wdata;
        `HMF_OFF_RT_LEVEL: rt_level_reg <= reg_wdata;
        default:           rt_level_reg <= rt_level_reg;
      endcase
    end
  end
  // ============================================================
  // fire bit, process control
  always @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      fire_bit_reg     <= 1'b0;
      fire_signal_reg  <= 1'b0;
      busy_reg         <= 1'b0;
      slot_idx_reg     <= 3'h0;
      wave_id_reg      <= 8'h00;
      wave_start_reg   <= 1'b0;
      cal_run_reg      <= 1'b0;
      diag_run_reg     <= 1'b0;
      proc_cnt_reg     <= 16'h0000;
      short_flag_reg   <= 1'b0;
      short_lock_reg   <= 1'b0;
    end
    else
    begin
      wave_start_reg  <= 1'b0;
      fire_signal_reg <= fire_next && can_run; // RL4
      if (trig_md)
        fire_bit_reg <= trig; // RL9
      else if (wr_fire)
        fire_bit_reg <= reg_wdata[0]; // RL5
      // flag raised only by a running process, dropped once the short is gone
      if (!short_sync_reg[1])
        short_flag_reg <= 1'b0; // RL12
      else if (busy_reg || cal_run_reg || diag_run_reg)
        short_flag_reg <= 1'b1; // RL13
      if ((busy_reg || cal_run_reg || diag_run_reg) && short_sync_reg[1])
        short_lock_reg <= 1'b1; // RL12
      else if (wr_mode && reg_wdata[2:0] != mode)
        short_lock_reg <= 1'b0; // RL11
      if (hold || short_lock_reg || (wr_fire && !reg_wdata[0] && !trig_md))
      begin
        busy_reg     <= 1'b0; // RL25 RL8
        cal_run_reg  <= 1'b0;
        diag_run_reg <= 1'b0;
        if (short_lock_reg)
          fire_bit_reg <= 1'b0;
      end
      else if (cal_run_reg || diag_run_reg)
      begin
        proc_cnt_reg <= proc_cnt_reg + 16'h0001;
        if (proc_cnt_reg == PROC_CYC[15:0])
        begin
          cal_run_reg  <= 1'b0;
          diag_run_reg <= 1'b0;
          if (!trig_md)
            fire_bit_reg <= 1'b0;
        end
      end
      else if (busy_reg)
      begin
        if (wave_done)
        begin
          if (last_slot)
          begin
            busy_reg <= 1'b0;
            if (!trig_md)
              fire_bit_reg <= 1'b0; // RL7
          end
          else
          begin
            slot_idx_reg   <= slot_idx_reg + 3'h1; // RL6
            wave_id_reg    <= slot_reg[slot_idx_reg + 3'h1];
            wave_start_reg <= 1'b1;
          end
        end
      end
      // fire must still stand: a bit cleared by the process end must not restart it
      else if (fire_signal_reg && fire_next)
      begin
        proc_cnt_reg <= 16'h0000;
        if (mode == `HMF_MODE_CAL)
          cal_run_reg <= 1'b1; // RL3 RL6
        else if (mode == `HMF_MODE_DIAG)
          diag_run_reg <= 1'b1; // RL3
        else if (!stream_md && mode != `HMF_MODE_EXTIN && slot_reg[0] != 8'h00)
        begin
          busy_reg       <= 1'b1;
          slot_idx_reg   <= 3'h0;
          wave_id_reg    <= slot_reg[0];
          wave_start_reg <= 1'b1;
        end
      end
    end
  end
  // ============================================================
  // drive level and open-loop toggle
  reg  [7:0] ol_cnt_reg;
  wire       streaming = stream_md && fire_signal_reg;
  wire       active    = busy_reg || cal_run_reg || diag_run_reg || streaming;
  wire [7:0] closed_lv = (steady_reg > peak_reg) ? peak_reg : steady_reg; // RL22
  wire [7:0] level     = open_lp ? peak_reg : closed_lv; // RL21 RL20 RL24
  always @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      drive_enable_reg <= 1'b0;
      drive_level_reg  <= 8'h00;
      ol_toggle_reg    <= 1'b0;
      ol_cnt_reg       <= 8'h00;
    end
    else
    begin
      drive_enable_reg <= active && can_run && !short_sync_reg[1]; // RL12
      drive_level_reg  <= (mode == `HMF_MODE_RT) ? rt_level_reg : level;
      if (active && open_lp && is_lra)
      begin
        // toggles only when the library select LRA bit is set
        if (ol_cnt_reg == 8'h00)
        begin
          ol_cnt_reg    <= {1'b0, ctrl1_reg[6:0]}; // RL14
          ol_toggle_reg <= !ol_toggle_reg;
        end
        else
          ol_cnt_reg <= ol_cnt_reg - 8'h01;
      end
      else
        ol_cnt_reg <= 8'h00;
    end
  end
  // ============================================================
  // back-emf sense timing
  wire       hiz_w;
  wire       conv_w;
  always @(posedge core_clk)
  begin
    hiz_reg     <= hiz_w;
    convert_reg <= conv_w;
  end
  hmf_sense_timer u_sense (
    .core_clk        (core_clk),
    .srst            (dev_rst),
    .run             (active && !open_lp),
    .drive_time      (ctrl1_reg[`HMF_DRIVE_MSB:0]),
    .decay_time      (ctrl2_reg[`HMF_DECAY_MSB:`HMF_DECAY_LSB]),
    .blank_time      (ctrl2_reg[`HMF_BLANK_MSB:`HMF_BLANK_LSB]),
    .zc_time         (ctrl3_reg[`HMF_ZC_MSB:`HMF_ZC_LSB]),
    .zc_seen         (zc_sync_reg[1]),
    .hiz_reg         (hiz_w),
    .convert_reg     (conv_w),
    .half_period_reg ()
  );
  // ============================================================
  // read mux
  always @(posedge core_clk)
  begin
    if (srst)
      reg_rdata_reg <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `HMF_OFF_STATUS:   reg_rdata_reg <= {6'h00, busy_reg, short_flag_reg};
        `HMF_OFF_MODE:     reg_rdata_reg <= mode_reg;
        `HMF_OFF_RT_LEVEL: reg_rdata_reg <= rt_level_reg;
        `HMF_OFF_FIRE:     reg_rdata_reg <= {7'h00, fire_bit_reg};
        `HMF_OFF_STEADY:   reg_rdata_reg <= steady_reg;
        `HMF_OFF_PEAK:     reg_rdata_reg <= peak_reg;
        `HMF_OFF_LIBSEL:   reg_rdata_reg <= libsel_reg;
        `HMF_OFF_CTRL1:    reg_rdata_reg <= ctrl1_reg;
        `HMF_OFF_CTRL2:    reg_rdata_reg <= ctrl2_reg;
        `HMF_OFF_CTRL3:    reg_rdata_reg <= ctrl3_reg;
        default:
        begin
          if (reg_addr >= `HMF_OFF_SLOT_FIRST && reg_addr <= `HMF_OFF_SLOT_LAST)
            reg_rdata_reg <= slot_reg[reg_addr[2:0] - 3'h4];
          else
            reg_rdata_reg <= 8'h00;
        end
      endcase
    end
  end
endmodule // hmf_fire_ctrl

// ### hmf_fire_ctrl_monitor.sv
// checker for mode, fire, short and hold behaviour at the fire control ports
`timescale 1ns/1ps
`include "hmf_regs.vh"
module hmf_fire_ctrl_monitor (
  input wire       core_clk,
  input wire       srst,
  input wire       reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       ext_trig,
  input wire       out_short,
  input wire       regulator_short,
  input wire       fire_signal_reg,
  input wire [7:0] wave_id_reg,
  input wire       wave_start_reg,
  input wire       cal_run_reg,
  input wire       diag_run_reg,
  input wire       drive_enable_reg
);
  // ============================================================
  // shadow of the mode field and hold bit
  reg [2:0] mode_reg;
  reg       hold_reg;
  always @(posedge core_clk)
  begin
    if (srst || regulator_short)
    begin
      mode_reg <= 3'h0;
      hold_reg <= 1'b1;
    end
    else if (reg_wr && reg_addr == `HMF_OFF_MODE)
    begin
      mode_reg <= reg_wdata[7] ? 3'h0 : reg_wdata[2:0];
      hold_reg <= reg_wdata[7] | reg_wdata[6];
    end
  end
  // ============================================================
  // properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  sequence s_fire_clear;
    reg_wr && reg_addr == `HMF_OFF_FIRE && !reg_wdata[0] && mode_reg == `HMF_MODE_SOFT;
  endsequence
  sequence s_hold_set;
    reg_wr && reg_addr == `HMF_OFF_MODE && reg_wdata[6];
  endsequence
  a_start_needs_fire: assert property (wave_start_reg && mode_reg == `HMF_MODE_SOFT
    |-> $past(fire_signal_reg) && wave_id_reg != 8'h00) else $error("start without fire");
  a_cal_needs_fire: assert property ($rose(cal_run_reg)
    |-> $past(fire_signal_reg) && mode_reg == `HMF_MODE_CAL) else $error("bad cal start");
  a_diag_needs_fire: assert property ($rose(diag_run_reg)
    |-> $past(fire_signal_reg) && mode_reg == `HMF_MODE_DIAG) else $error("bad diag start");
  a_cancel_now: assert property (s_fire_clear |-> ##[1:3] !fire_signal_reg)
    else $error("fire not dropped");
  a_level_high: assert property ((mode_reg == `HMF_MODE_LEVEL && ext_trig && !hold_reg)[*6]
    |-> fire_signal_reg) else $error("level trigger ignored");
  a_level_low: assert property ((mode_reg == `HMF_MODE_LEVEL && !ext_trig)[*6]
    |-> !fire_signal_reg) else $error("fire without trigger");
  a_rt_fires: assert property ((mode_reg == `HMF_MODE_RT && !hold_reg)[*4]
    |-> fire_signal_reg) else $error("realtime not fired");
  a_short_cuts: assert property (out_short && drive_enable_reg
    |-> ##[1:5] !drive_enable_reg) else $error("drive kept on short");
  a_hold_stops: assert property (s_hold_set |-> ##3 !drive_enable_reg && !wave_start_reg)
    else $error("hold did not stop");
  a_reg_short_off: assert property (regulator_short[*6]
    |-> !fire_signal_reg && !drive_enable_reg && !cal_run_reg) else $error("alive in reg short");
endmodule // hmf_fire_ctrl_monitor

bind hmf_fire_ctrl hmf_fire_ctrl_monitor u_mon (
  .core_clk(core_clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .ext_trig(ext_trig), .out_short(out_short),
  .regulator_short(regulator_short), .fire_signal_reg(fire_signal_reg),
  .wave_id_reg(wave_id_reg), .wave_start_reg(wave_start_reg), .cal_run_reg(cal_run_reg),
  .diag_run_reg(diag_run_reg), .drive_enable_reg(drive_enable_reg)
);

// ### hmf_host_model.sv
// host processor model issuing register strobes
`timescale 1ns/1ps
`include "hmf_regs.vh"
module hmf_host_model (
  input  wire       core_clk,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata_reg
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // idle bus shows inverted values, never the last ones
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_reg;
  end
  endtask
  task fire;
    wr(`HMF_OFF_FIRE, 8'h01);
  endtask
  // levels first, then the calibration run
  task calibrate(input [7:0] s, input [7:0] p);
  begin
    wr(`HMF_OFF_STEADY, s);
    wr(`HMF_OFF_PEAK, p);
    wr(`HMF_OFF_MODE, {5'h00, `HMF_MODE_CAL});
    fire;
  end
  endtask
endmodule // hmf_host_model

// ### hmf_fire_ctrl_tb_top.sv
// testbench for the mode and fire control block
`timescale 1ns/1ps
`include "hmf_regs.vh"
`define CHK(got, exp) \
  begin \
    tests_run = tests_run + 1; \
    if ((got) !== (exp)) \
    begin \
      error_cnt = error_cnt + 1; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module hmf_fire_ctrl_tb_top;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg         ext_trig = 1'b0;
  reg         out_short = 1'b0;
  reg         regulator_short = 1'b0;
  reg         zc_seen = 1'b0;
  reg         wave_done = 1'b0;
  reg   [3:0] busy_cnt = 4'h0;
  reg         cal_seen = 1'b0;
  reg         diag_seen = 1'b0;
  reg         tog_seen = 1'b0;
  wire  [7:0] drive_level_reg;
  wire        ol_toggle_reg;
  reg   [7:0] d;
  wire        reg_wr;
  wire        reg_rd;
  wire  [7:0] reg_addr;
  wire  [7:0] reg_wdata;
  wire  [7:0] reg_rdata_reg;
  wire        fire_signal_reg;
  wire  [7:0] wave_id_reg;
  wire        wave_start_reg;
  wire        cal_run_reg;
  wire        diag_run_reg;
  wire        drive_enable_reg;
  integer     error_cnt = 0;
  integer     tests_run = 0;
  integer     i;
  reg   [7:0] ids[$];
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) zc_seen <= #1 busy_cnt[2];
  hmf_host_model host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg));
  hmf_fire_ctrl #(.PROC_CYC(20)) dut (.core_clk(core_clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg),
    .ext_trig(ext_trig), .out_short(out_short), .regulator_short(regulator_short),
    .zc_seen(zc_seen), .wave_done(wave_done), .fire_signal_reg(fire_signal_reg),
    .wave_id_reg(wave_id_reg), .wave_start_reg(wave_start_reg), .cal_run_reg(cal_run_reg),
    .diag_run_reg(diag_run_reg), .drive_enable_reg(drive_enable_reg),
    .drive_level_reg(drive_level_reg), .ol_toggle_reg(ol_toggle_reg), .hiz_reg(),
    .convert_reg());
  // ============================================================
  // waveform engine: each id takes eight cycles
  always @(posedge core_clk)
  begin
    wave_done <= #1 1'b0;
    tog_seen <= tog_seen | ol_toggle_reg;
    cal_seen <= cal_seen | cal_run_reg;
    diag_seen <= diag_seen | diag_run_reg;
    if (wave_start_reg)
    begin
      ids.push_back(wave_id_reg);
      busy_cnt <= 4'h8;
    end
    else if (busy_cnt != 4'h0)
    begin
      busy_cnt <= busy_cnt - 4'h1;
      wave_done <= #1 (busy_cnt == 4'h1);
    end
  end
  // ============================================================
  // helpers
  task step(input integer n);
  begin
    repeat (n) @(posedge core_clk);
    #1;
  end
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
  begin
    host.rd(a, d);
    `CHK(d, e)
  end
  endtask
  task wait_starts(input integer n);
    integer k;
  begin
    for (k = 0; k < 400 && ids.size() < n; k = k + 1)
      @(posedge core_clk);
    `CHK(ids.size() >= n, 1'b1)
  end
  endtask
  task play(input integer n);
    integer k;
  begin
    ids.delete();
    host.fire();
    wait_starts(1);
    rd_chk(`HMF_OFF_FIRE, 8'h01);
    d = 8'h01;
    for (k = 0; k < 200 && d !== 8'h00; k = k + 1)
      host.rd(`HMF_OFF_FIRE, d);
    `CHK(d, 8'h00)
    `CHK(ids.size(), n)
  end
  endtask
  task give_verdict;
  begin
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    step(3);
    srst = 1'b0;
    rd_chk(`HMF_OFF_MODE, `HMF_RST_MODE);
    rd_chk(`HMF_OFF_STEADY, `HMF_RST_STEADY);
    rd_chk(`HMF_OFF_PEAK, `HMF_RST_PEAK);
    host.wr(8'h30, 8'h5a);
    rd_chk(8'h30, 8'h00);
    for (i = 0; i < 8; i = i + 1)
      host.wr(`HMF_OFF_SLOT_FIRST + i, 8'h11 * (i + 1));
    for (i = 0; i < 8; i = i + 1)
      rd_chk(`HMF_OFF_SLOT_FIRST + i, 8'h11 * (i + 1));
    host.wr(`HMF_OFF_MODE, 8'h00);
    play(8);
    `CHK(ids[7], 8'h88)
    host.wr(`HMF_OFF_SLOT_FIRST + 2, 8'h00);
    play(2);
    ids.delete();
    host.fire();
    wait_starts(1);
    host.wr(`HMF_OFF_FIRE, 8'h00);
    step(40);
    `CHK(ids.size(), 1)
    host.wr(`HMF_OFF_MODE, {5'h00, `HMF_MODE_LEVEL});
    host.fire();
    rd_chk(`HMF_OFF_FIRE, 8'h00);
    ext_trig = 1'b1;
    step(10);
    rd_chk(`HMF_OFF_FIRE, 8'h01);
    `CHK(fire_signal_reg, 1'b1)
    ext_trig = 1'b0;
    step(60);
    rd_chk(`HMF_OFF_FIRE, 8'h00);
    host.wr(`HMF_OFF_MODE, {5'h00, `HMF_MODE_EDGE});
    ids.delete();
    ext_trig = 1'b1;
    step(6);
    ext_trig = 1'b0;
    wait_starts(1);
    step(40);
    host.wr(`HMF_OFF_MODE, {5'h00, `HMF_MODE_RT});
    step(6);
    `CHK(fire_signal_reg, 1'b1)
    `CHK(drive_enable_reg, 1'b1)
    out_short = 1'b1;
    step(6);
    `CHK(drive_enable_reg, 1'b0)
    out_short = 1'b0;
    rd_chk(`HMF_OFF_FIRE, 8'h00);
    host.wr(`HMF_OFF_CTRL3, 8'h01);
    host.wr(`HMF_OFF_MODE, {5'h00, `HMF_MODE_EXTIN});
    step(6);
    `CHK(fire_signal_reg, 1'b0)
    host.wr(`HMF_OFF_CTRL3, 8'h03);
    step(6);
    `CHK(fire_signal_reg, 1'b1)
    rd_chk(`HMF_OFF_FIRE, 8'h00);
    host.calibrate(8'h5a, 8'h33);
    step(60);
    `CHK({cal_seen, cal_run_reg}, 2'b10)
    host.wr(`HMF_OFF_MODE, {5'h00, `HMF_MODE_DIAG});
    host.fire();
    step(60);
    `CHK({diag_seen, diag_run_reg}, 2'b10)
    `CHK(drive_level_reg, 8'h33)
    host.wr(`HMF_OFF_PEAK, 8'hff);
    step(2);
    `CHK(drive_level_reg, 8'h5a)
    host.wr(`HMF_OFF_LIBSEL, 8'h80);
    host.wr(`HMF_OFF_CTRL3, 8'h20);
    step(2);
    `CHK(drive_level_reg, 8'hff)
    host.wr(`HMF_OFF_MODE, 8'h00);
    out_short = 1'b1;
    step(10);
    host.rd(`HMF_OFF_STATUS, d);
    `CHK(d[0], 1'b0)
    host.fire();
    step(10);
    host.rd(`HMF_OFF_STATUS, d);
    `CHK({d[0], drive_enable_reg}, 2'b10)
    out_short = 1'b0;
    step(10);
    host.rd(`HMF_OFF_STATUS, d);
    `CHK(d[0], 1'b0)
    host.wr(`HMF_OFF_FIRE, 8'h00);
    ids.delete();
    host.fire();
    step(30);
    `CHK(ids.size(), 0)
    host.wr(`HMF_OFF_FIRE, 8'h00);
    host.wr(`HMF_OFF_MODE, {5'h00, `HMF_MODE_EDGE});
    host.wr(`HMF_OFF_MODE, 8'h00);
    play(2);
    `CHK(tog_seen, 1'b1)
    ids.delete();
    host.fire();
    wait_starts(1);
    host.wr(`HMF_OFF_MODE, 8'h40);
    step(40);
    `CHK(ids.size(), 1)
    rd_chk(`HMF_OFF_STEADY, 8'h5a);
    regulator_short = 1'b1;
    step(8);
    regulator_short = 1'b0;
    step(6);
    rd_chk(`HMF_OFF_STEADY, `HMF_RST_STEADY);
    rd_chk(`HMF_OFF_MODE, `HMF_RST_MODE);
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule // hmf_fire_ctrl_tb_top
